// ===== cdlm_consts.vh
/*
  Constants for the clock deskew lock manager: timing counts, delay line
  size and input source codes. Assumes a 100 MHz mclk sampling clock.
*/
`ifndef CDLM_CONSTS_VH
`define CDLM_CONSTS_VH

// Sampling clock period in ns
`define CDLM_MCLK_PERIOD_NS     10
// Delay line taps, one mclk period each
`define CDLM_TAP_BITS           6
`define CDLM_TAPS               64
// Period counter width in bits; the counter counts mclk cycles
`define CDLM_PER_BITS           12
// Consecutive matching feedback edges needed for lock (several thousand)
`define CDLM_LOCK_SAMPLES       3000
// Allowed period drift in mclk cycles before lock is dropped
`define CDLM_PERIOD_TOL         2
// Input clock source codes
`define CDLM_SRC_GLOBAL_INPUT   2'h0
`define CDLM_SRC_GLOBAL_BUFFER  2'h1
`define CDLM_SRC_GENERAL_INPUT  2'h2
`define CDLM_SRC_LOGIC          2'h3
// Characterized path delays removed from the output, in taps
`define CDLM_GLOBAL_INPUT_TAPS  6'h02
`define CDLM_GLOBAL_BUFFER_TAPS 6'h01

`endif

// ===== cdlm_edge_detect.v
/*
  Rising-edge detector for a sampled clock level.
  Assumes the input is already synchronous to mclk.
*/
`timescale 1ns/1ps
module cdlm_edge_detect (
  // Clock and control
  input  wire mclk,
  input  wire sys_rst,
  input  wire clk_en,
  // Sampled level and edge pulse
  input  wire level_in,
  output wire rise
);
  reg last;

  // Previous sample for edge compare
  always @(posedge mclk) begin
    if (sys_rst) begin
      last <= level_in; // Follow the pin so a high idle level is no false edge
    end else if (clk_en) begin
      last <= level_in;
    end
  end

  assign rise = level_in & ~last & clk_en;
endmodule

// ===== cdlm_delay_line.v
/*
  Tapped delay line on the sampled input clock, one mclk per tap.
  Assumes the tap select is steady or changes slowly.
*/
`timescale 1ns/1ps
`include "cdlm_consts.vh"
module cdlm_delay_line #(
  parameter TAPS     = `CDLM_TAPS,
  parameter TAP_BITS = `CDLM_TAP_BITS
) (
  // Clock and control
  input  wire                mclk,
  input  wire                sys_rst,
  input  wire                clk_en,
  // Clock in, tap select and delayed clock out
  input  wire                clk_in,
  input  wire [TAP_BITS-1:0] tap_sel,
  output reg                 clk_out
);
  reg [TAPS-1:0] line;

  // Shift line; taps spanning several periods are allowed
  always @(posedge mclk) begin
    if (sys_rst) begin
      line    <= {TAPS{1'b0}};
      clk_out <= 1'b0;
    end else if (clk_en) begin
      line    <= {line[TAPS-2:0], clk_in};
      clk_out <= line[tap_sel];
    end
  end
endmodule

// ===== cdlm_clock_deskew_lock_manager.v
/*
  Delay-locked deskew manager, modelled in the mclk sampling domain.
  It times the input clock, delays it through a tapped line, and steers
  the tap until the feedback clock edge lines up with the input edge.
  Assumes input_clock and feedback_clock are sampled levels synchronous
  to mclk and that feedback_clock is tapped after the distribution path.
*/
`timescale 1ns/1ps
`include "cdlm_consts.vh"
// What this block does
// - Watch input clock for thousands of cycles while searching for the aligning delay.
// - Raise lock indicator once the aligning delay is in place.
// - Output clocks may glitch and are unqualified while acquiring.
// - Drop lock when input period strays far outside tolerance.
// - Within tolerance, outputs are valid whenever lock is high.
// - Far out of limits, lock drops and period_fault stays high until reset.
// - Delay output by one period minus path delay.
// - Keep tracking feedback after lock to follow slow drift.
// - Remove characterized global input buffer delay from output.
// - Remove characterized global clock buffer delay from output.
// - General input buffer delay is left uncompensated.
// - Logic-generated input clock delay is left uncompensated.
// - Accept any feedback delay, spanning several periods if needed.
// - Compare input with feedback tapped after distribution delay.
module cdlm_clock_deskew_lock_manager #(
  parameter TAPS          = `CDLM_TAPS,
  parameter TAP_BITS      = `CDLM_TAP_BITS,
  parameter PER_BITS      = `CDLM_PER_BITS,
  parameter LOCK_SAMPLES  = `CDLM_LOCK_SAMPLES,
  parameter PERIOD_TOL    = `CDLM_PERIOD_TOL
) (
  // Clock, reset and enable
  input  wire                mclk,
  input  wire                sys_rst,
  input  wire                clk_en,
  // Clock source side
  input  wire                input_clock,
  input  wire [1:0]          input_source,
  // Load side
  input  wire                feedback_clock,
  output reg                 zero_phase_clock_output,
  output reg                 lock_indicator,
  output reg                 period_fault,
  output reg [TAP_BITS-1:0]  inserted_delay
);
  localparam ST_MEASURE = 2'h0;
  localparam ST_SEARCH  = 2'h1;
  localparam ST_LOCKED  = 2'h2;
  localparam ST_LOST    = 2'h3;

  reg  [1:0]          state;
  reg  [1:0]          next_state;
  reg  [PER_BITS-1:0] per_cnt;
  reg  [PER_BITS-1:0] period;
  reg                 period_valid;
  reg  [PER_BITS-1:0] phase_cnt;
  reg                 fb_seen;
  reg  [13:0]         match_cnt;
  reg  [TAP_BITS-1:0] tap;
  wire                in_rise;
  wire                fb_rise;
  reg  [1:0]          fb_hist;
  wire                fb_cmp;
  wire                delayed_clk;
  wire [TAP_BITS-1:0] comp;
  wire [TAP_BITS-1:0] out_tap;
  wire                period_bad;

  // Characterized buffer delay for the chosen source
  function [TAP_BITS-1:0] source_comp;
    input [1:0] src;
    begin
      case (src)
        `CDLM_SRC_GLOBAL_INPUT:  source_comp = `CDLM_GLOBAL_INPUT_TAPS;
        `CDLM_SRC_GLOBAL_BUFFER: source_comp = `CDLM_GLOBAL_BUFFER_TAPS;
        `CDLM_SRC_GENERAL_INPUT: source_comp = {TAP_BITS{1'b0}};
        default:                 source_comp = {TAP_BITS{1'b0}};
      endcase
    end
  endfunction

  // Absolute difference of two period counts
  function [PER_BITS-1:0] abs_diff;
    input [PER_BITS-1:0] a;
    input [PER_BITS-1:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  cdlm_edge_detect u_in_edge (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .level_in (input_clock),
    .rise     (in_rise)
  );

  // Feedback tapped after distribution is the alignment reference
  cdlm_edge_detect u_fb_edge (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .level_in (fb_cmp),
    .rise     (fb_rise)
  );

  // Removed buffer delay for the chosen source
  assign comp    = source_comp(input_source);
  // Loop output tap; the compensation acts on the compared feedback instead.
  // Subtracting it from the tap would be undone by the closed loop.
  assign out_tap = tap;

  // Recent feedback levels, so the compare sees feedback comp taps late
  always @(posedge mclk) begin
    if (sys_rst) begin
      fb_hist <= 2'h0;
    end else if (clk_en) begin
      fb_hist <= {fb_hist[0], feedback_clock};
    end
  end

  // Late compare makes the loop lock with feedback early by comp taps.
  // Limitation: compensation above two taps is not supported.
  assign fb_cmp = (comp == {TAP_BITS{1'b0}}) ? feedback_clock :
                  (comp == {{(TAP_BITS-1){1'b0}}, 1'b1}) ? fb_hist[0] :
                  fb_hist[1];

  cdlm_delay_line #(
    .TAPS     (TAPS),
    .TAP_BITS (TAP_BITS)
  ) u_line (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .clk_in   (input_clock),
    .tap_sel  (out_tap),
    .clk_out  (delayed_clk)
  );

  // Period measurement between input rising edges
  always @(posedge mclk) begin
    if (sys_rst) begin
      per_cnt      <= {PER_BITS{1'b0}};
      period       <= {PER_BITS{1'b0}};
      period_valid <= 1'b0;
    end else if (clk_en) begin
      if (in_rise) begin
        per_cnt <= {{(PER_BITS-1){1'b0}}, 1'b1};
        if (per_cnt != {PER_BITS{1'b0}}) begin
          period       <= per_cnt;
          period_valid <= 1'b1;
        end
      end else if (per_cnt != {PER_BITS{1'b1}}) begin
        per_cnt <= per_cnt + {{(PER_BITS-1){1'b0}}, 1'b1};
      end
    end
  end

  // Stray period: a new edge off by more than the tolerance, or none at all
  assign period_bad = period_valid &&
                      ((in_rise && (abs_diff(per_cnt, period) > PERIOD_TOL)) ||
                       (per_cnt > (period + PERIOD_TOL[PER_BITS-1:0])));

  // Phase of feedback edge relative to last input edge
  always @(posedge mclk) begin
    if (sys_rst) begin
      phase_cnt <= {PER_BITS{1'b0}};
      fb_seen   <= 1'b0;
    end else if (clk_en) begin
      if (in_rise) begin
        phase_cnt <= {PER_BITS{1'b0}};
        fb_seen   <= fb_rise;
      end else begin
        if (phase_cnt != {PER_BITS{1'b1}}) begin
          phase_cnt <= phase_cnt + {{(PER_BITS-1){1'b0}}, 1'b1};
        end
        if (fb_rise) begin
          fb_seen <= 1'b1;
        end
      end
    end
  end

  // Tap steering: an input edge with no feedback edge steps the tap up; it steps down only if phase_cnt is under half the period then.
  // Tap wraps, so feedback delays spanning several periods still settle.
  always @(posedge mclk) begin
    if (sys_rst) begin
      tap       <= {TAP_BITS{1'b0}};
      match_cnt <= 14'h0000;
    end else if (clk_en && in_rise && state != ST_LOST && state != ST_MEASURE) begin
      if (fb_rise) begin
        if (match_cnt != 14'h3FFF) begin
          match_cnt <= match_cnt + 14'h0001;
        end
      end else begin
        match_cnt <= 14'h0000;
        if (fb_seen && phase_cnt < (period >> 1)) begin
          tap <= tap - {{(TAP_BITS-1){1'b0}}, 1'b1};
        end else begin
          tap <= tap + {{(TAP_BITS-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Lock state transitions
  always @* begin
    next_state = state;
    case (state)
      ST_MEASURE: if (period_valid) next_state = ST_SEARCH;
      ST_SEARCH: begin
        if (period_bad) begin
          next_state = ST_MEASURE;
        end else if (match_cnt >= LOCK_SAMPLES) begin
          next_state = ST_LOCKED;
        end
      end
      ST_LOCKED: if (period_bad) next_state = ST_LOST;
      ST_LOST:    next_state = ST_LOST;
      default:    next_state = ST_MEASURE;
    endcase
  end

  // State register and registered outputs
  always @(posedge mclk) begin
    if (sys_rst) begin
      state                   <= ST_MEASURE;
      lock_indicator          <= 1'b0;
      period_fault            <= 1'b0;
      inserted_delay          <= {TAP_BITS{1'b0}};
      zero_phase_clock_output <= 1'b0;
    end else if (clk_en) begin
      state          <= next_state;
      lock_indicator <= (next_state == ST_LOCKED);
      period_fault   <= (next_state == ST_LOST); // no divided outputs here
      inserted_delay <= out_tap;
      // Passed through while acquiring; may glitch until locked
      zero_phase_clock_output <= delayed_clk;
    end
  end
endmodule

// ===== cdlm_lock_checker_assertions.sv
/*
  Port checker for the lock manager. Assumes the bind passes on LOCK_SAMPLES.
*/
`timescale 1ns/1ps
module cdlm_lock_checker #(parameter LOCK_SAMPLES = 3000) (
  // Clock and control
  input wire       mclk,
  input wire       sys_rst,
  input wire       clk_en,
  // Clocks and outputs
  input wire       input_clock,
  input wire       feedback_clock,
  input wire [1:0] input_source,
  input wire       lock_indicator,
  input wire       period_fault,
  input wire [5:0] inserted_delay
);
  reg        in_q, fb_q, hit;
  reg [15:0] rises;
  reg [3:0]  fb_age;
  wire [3:0] fb_now, comp_want;
  // Cycles since the last feedback edge, saturating
  assign fb_now = (feedback_clock && !fb_q) ? 4'h0 : (&fb_age ? fb_age : fb_age + 4'h1);
  // Feedback leads the input by the removed buffer delay of the source
  assign comp_want = (input_source == 2'h0) ? 4'h2 : (input_source == 2'h1) ? 4'h1 : 4'h0;
  default clocking dcb @(posedge mclk);
  endclocking
  // Input edges since reset, saturating so a long run cannot wrap
  always @(posedge mclk) begin
    if (clk_en) begin
      in_q <= input_clock;
      fb_q <= feedback_clock;
    end
    if (sys_rst) begin
      hit    <= 1'b0;
      rises  <= 16'h0000;
      fb_age <= 4'hF;
    end else if (clk_en) begin
      fb_age <= fb_now;
      if (input_clock && !in_q) begin
        hit   <= (fb_now == comp_want);
        rises <= rises + {15'h0000, ~&rises};
      end
    end
  end
  // Reset with clk_en high clears lock, fault and delay
  a_reset_drops_lock: assert property (sys_rst && clk_en |=> !lock_indicator)
    else $error("lock after reset");
  a_reset_clears: assert property (sys_rst && clk_en |=> !period_fault && !inserted_delay)
    else $error("outputs after reset");
  // Loss of lock is sticky until reset
  a_fault_sticky: assert property (disable iff (sys_rst) period_fault |=> period_fault)
    else $error("fault cleared");
  a_fault_no_lock: assert property (disable iff (sys_rst)
    period_fault && $past(period_fault) |-> !lock_indicator) else $error("lock in fault");
  a_loss_faults: assert property (disable iff (sys_rst)
    $fell(lock_indicator) && !$past(sys_rst) |-> ##[0:1] period_fault) else $error("silent loss");
  // Lock only after enough aligned edges; delay and lock hold while clk_en is low
  a_lock_on_match: assert property (disable iff (sys_rst) $rose(lock_indicator) |-> hit)
    else $error("lock unaligned");
  a_lock_late_enough: assert property (disable iff (sys_rst)
    $rose(lock_indicator) |-> rises >= LOCK_SAMPLES) else $error("lock too early");
  a_frozen_off: assert property (disable iff (sys_rst)
    !clk_en |=> $stable(inserted_delay) && $stable(lock_indicator)) else $error("moved while off");
  c_locked: cover property ($rose(lock_indicator));
  c_lost: cover property ($rose(period_fault));
  c_frozen: cover property (!clk_en);
endmodule

bind cdlm_clock_deskew_lock_manager cdlm_lock_checker #(.LOCK_SAMPLES(LOCK_SAMPLES)) u_chk (
  .mclk, .sys_rst, .clk_en, .input_clock, .feedback_clock, .input_source, .lock_indicator,
  .period_fault,
  .inserted_delay);

// ===== cdlm_source_model.sv
/*
  Clock source and distribution path. Assumes period of 4 or more, delay under 16.
*/
`timescale 1ns/1ps
module cdlm_source_model (
  // Clock and settings
  input  wire       mclk,
  input  wire [7:0] period,
  input  wire [3:0] dist_delay,
  // Manager side
  input  wire       zero_phase_clock_output,
  output reg        input_clock = 1'b0,
  output reg        feedback_clock = 1'b0
);
  reg [7:0]  phase = 8'h00;
  reg [15:0] path = 16'h0000;
  // Free-running source; loads see the output after the path delay
  always @(posedge mclk) begin
    phase <= (phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
    input_clock <= phase < {1'b0, period[7:1]};
    path <= {path[14:0], zero_phase_clock_output};
    feedback_clock <= path[dist_delay];
  end
endmodule

// ===== test_clock_deskew_lock_manager.sv
/*
  Bench for the lock manager with a source model. Assumes the checker is bound in.
*/
`timescale 1ns/1ps
module test_clock_deskew_lock_manager;
  reg        mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, ip, fp;
  reg  [1:0] input_source = 2'h2;
  reg  [7:0] period = 8'h0C;
  reg  [3:0] dist_delay = 4'h3;
  reg  [5:0] dly [0:3];
  wire       input_clock, feedback_clock, zero_phase_clock_output, lock_indicator, period_fault;
  wire [5:0] inserted_delay;
  integer    mismatches = 0, checks_done = 0, cycles = 0, i, s, fa;
  always #5 mclk = ~mclk;
  cdlm_clock_deskew_lock_manager #(.LOCK_SAMPLES(8)) i_dut (.mclk, .sys_rst, .clk_en,
    .input_clock, .input_source, .feedback_clock, .zero_phase_clock_output, .lock_indicator,
    .period_fault, .inserted_delay);
  cdlm_source_model i_src (.mclk, .period, .dist_delay, .zero_phase_clock_output,
    .input_clock, .feedback_clock);
  task check(input [7:0] seen, input [7:0] want);
    checks_done = checks_done + 1;
    if (seen !== want) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: %h, expected %h", $time, seen, want);
    end
  endtask
  task give_verdict;
    $display("%0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far above the expected run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  // Called at a rising edge
  task do_reset;
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask
  task wait_lock(input v);
    for (i = 0; i < 8000 && lock_indicator !== v; i = i + 1) @(posedge mclk);
  endtask
  // Removed buffer delay of each source, in taps
  function [7:0] src_comp(input [1:0] src);
    src_comp = (src == 2'h0) ? 8'h02 : (src == 2'h1) ? 8'h01 : 8'h00;
  endfunction
  // Each input edge within three periods must follow a feedback edge by the source's removed delay
  task check_align;
    ip = 1'b1;
    fp = 1'b1;
    fa = 99;
    repeat (3 * period) begin
      @(negedge mclk);
      if (feedback_clock && !fp) fa = 0;
      else fa = fa + 1;
      if (input_clock && !ip) check(8'(fa), src_comp(s[1:0]));
      ip = input_clock;
      fp = feedback_clock;
    end
    @(posedge mclk);
  endtask
  initial begin
    void'($urandom(32'h0B375760));
    @(posedge mclk);
    do_reset;
    check({lock_indicator, period_fault, inserted_delay}, 8'h00);
    $display("reset test done");
    period <= 8'(10 + $urandom % 8);
    dist_delay <= 4'(1 + $urandom % 5);
    // Same clock through each source; a short freeze right after each reset, before the search
    for (s = 0; s < 4; s = s + 1) begin
      input_source <= s[1:0];
      do_reset;
      clk_en <= 1'b0;
      repeat (5) @(posedge mclk);
      clk_en <= 1'b1;
      wait_lock(1'b1);
      check(8'(lock_indicator), 8'h01);
      check_align;
      dly[s] = inserted_delay;
      $display("source %0d test done", s);
    end
    // Taps align modulo the input period, so compare differences modulo it
    check(8'((dly[2] + 8 * period - dly[0]) % period), 8'(2 % period));
    check(8'((dly[2] + 8 * period - dly[1]) % period), 8'(1 % period));
    check(8'((dly[2] + 8 * period - dly[3]) % period), 8'h00);
    // Period far out of tolerance, then no relock without reset
    period <= period + period + 8'h05;
    wait_lock(1'b0);
    @(posedge mclk);
    check(8'({lock_indicator, period_fault}), 8'h01);
    repeat (20 * period) @(posedge mclk);
    check(8'({lock_indicator, period_fault}), 8'h01);
    $display("loss test done");
    do_reset;
    wait_lock(1'b1);
    check(8'(lock_indicator), 8'h01);
    give_verdict;
  end
endmodule
